// ### hw/sar_adc_controller.sv
// Summary of operation
// - Ten-bit successive approximation of one of eight analog inputs.
// - Only the currently selected channel is converted.
// - Hardware start: chosen trigger edge (rise, fall, both) begins conversion.
// - Software start: setting run bit in mode register starts conversion.
// - Trigger-started conversion runs once, then raises end-of-conversion request.
// - Software-started conversions repeat; each completion raises the request.
// - Bits resolve MSB first; after LSB the value goes to result.
// - Result is 16 bits, left aligned, low six bits read zero.
// - Result reloads at the end of every completed conversion.
// - Result is read-only at its address, read as one 16-bit access.
// - Result is not reset; undefined until a conversion completes.
// - Mode holds conversion time, run control and trigger configuration.
// - Mode register takes single-bit and full-byte writes.
// - Reset clears mode register to zero, stopping the converter.
// - Mode: b7 run, b6 hardware start, b5-3 time, b2-1 edge.
// - Channel register low three bits pick inputs zero to seven.
// - Mode or channel rewrite aborts; restarts from first bit in software start, hardware start waits for a trigger.
`default_nettype none
`include "adc_defs.svh"
module sar_adc_controller (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [15:0] addr,
  input wire logic byte_wr,
  input wire logic [7:0] wr_data,
  input wire logic bit_wr,
  input wire logic [2:0] bit_idx,
  input wire logic bit_val,
  input wire logic rd_en,
  output logic [15:0] rd_data,
  input wire logic ext_conv_trigger,
  input wire logic comp_hi,
  output logic [9:0] tap_code,
  output logic sample_hold,
  output logic [2:0] analog_inputs_sel,
  output logic conv_end_irq
);
  import adc_pkg::*;

  sar_step_if step ();

  ctl_state_t state_q, state_d;
  logic [7:0] mode_q, mode_d;
  chan_t chan_q, chan_d;
  logic trig_q;
  logic [15:0] result_q, result_d;
  logic [15:0] rd_q, rd_d;
  logic irq_q, irq_d;
  logic mode_wr, chan_wr, any_wr;
  logic run, hw_mode, trig_edge;
  edge_sel_t edge_sel;
  logic [2:0] time_sel;
  logic [7:0] conv_clks;

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  assign mode_wr = (byte_wr || bit_wr) && (addr == `ADR_MODE);
  assign chan_wr = byte_wr && (addr == `ADR_CHAN);
  assign any_wr = mode_wr || chan_wr;

  always_comb begin
    mode_d = mode_q;
    chan_d = chan_q;
    if (byte_wr && addr == `ADR_MODE) begin
      mode_d = wr_data & `MODE_WMASK;
    end else if (bit_wr && addr == `ADR_MODE) begin
      mode_d[bit_idx] = bit_val;
      mode_d = mode_d & `MODE_WMASK;
    end
    if (chan_wr) begin
      chan_d = wr_data[2:0];
    end
  end

  // ----------------------------------------
  // Mode decode
  // ----------------------------------------
  // Decoding the new value lets an abort restart under the new settings
  assign run = mode_d[`MODE_RUN_BIT];
  assign hw_mode = mode_d[`MODE_HW_BIT];
  assign time_sel = mode_q[`MODE_FR_HI:`MODE_FR_LO];
  assign edge_sel = edge_sel_t'(mode_q[`MODE_EDGE_HI:`MODE_EDGE_LO]);

  // Prohibited time codes fall back to the slowest setting
  always_comb begin
    case (time_sel)
      3'b001: conv_clks = 8'(`CONV_CLKS_120);
      3'b010: conv_clks = 8'(`CONV_CLKS_96);
      3'b100: conv_clks = 8'(`CONV_CLKS_72);
      3'b101: conv_clks = 8'(`CONV_CLKS_60);
      3'b110: conv_clks = 8'(`CONV_CLKS_48);
      default: conv_clks = 8'(`CONV_CLKS_144);
    endcase
  end
  assign step.step_len = 4'(conv_clks / 8'(`STEPS_PER_CONV));

  // ----------------------------------------
  // Trigger edge detect
  // ----------------------------------------
  always_comb begin
    case (edge_sel)
      EDGE_FALL: trig_edge = trig_q && !ext_conv_trigger;
      EDGE_RISE: trig_edge = !trig_q && ext_conv_trigger;
      EDGE_BOTH: trig_edge = trig_q != ext_conv_trigger;
      default: trig_edge = 1'b0;
    endcase
  end

  // ----------------------------------------
  // Conversion sequencing
  // ----------------------------------------
  always_comb begin
    state_d = state_q;
    step.start = 1'b0;
    step.abort = 1'b0;
    if (any_wr) begin
      // Rewrite restarts from the first bit in software mode; hardware mode waits for a trigger
      step.abort = 1'b1;
      if (!run) begin
        state_d = CTL_IDLE;
      end else if (hw_mode) begin
        state_d = CTL_WAIT_TRIG;
      end else begin
        state_d = CTL_BUSY;
      end
    end else begin
      case (state_q)
        CTL_IDLE: begin
          if (run) begin
            state_d = hw_mode ? CTL_WAIT_TRIG : CTL_BUSY;
          end
        end
        CTL_WAIT_TRIG: begin
          if (trig_edge) begin
            state_d = CTL_BUSY;
          end
        end
        CTL_BUSY: begin
          if (step.done) begin
            // One shot in hardware mode, continuous in software mode
            state_d = hw_mode ? CTL_WAIT_TRIG : CTL_BUSY;
          end
        end
        default: state_d = CTL_IDLE;
      endcase
    end
    // Engine is kicked when entering busy, or staying in busy after a done or a rewrite
    if (state_d == CTL_BUSY && (state_q != CTL_BUSY || step.done || any_wr)) begin
      step.start = 1'b1;
    end
  end

  // ----------------------------------------
  // Result, interrupt and read port
  // ----------------------------------------
  always_comb begin
    result_d = result_q;
    irq_d = 1'b0;
    if (step.done && !any_wr) begin
      result_d = {step.sar_value, `RESULT_PAD};
      irq_d = 1'b1;
    end
  end

  always_comb begin
    rd_d = rd_q;
    if (rd_en) begin
      if (addr == `ADR_RESULT) begin
        rd_d = result_q;
      end else if (addr == `ADR_MODE) begin
        rd_d = {8'h00, mode_q};
      end else if (addr == `ADR_CHAN) begin
        rd_d = {13'h0, chan_q};
      end else begin
        rd_d = 16'h0000;
      end
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= CTL_IDLE;
      mode_q <= `MODE_RESET;
      chan_q <= `CHAN_RESET;
      trig_q <= 1'b0;
      rd_q <= 16'h0000;
      irq_q <= 1'b0;
    end else begin
      state_q <= state_d;
      mode_q <= mode_d;
      chan_q <= chan_d;
      trig_q <= ext_conv_trigger;
      rd_q <= rd_d;
      irq_q <= irq_d;
    end
  end

  // Result deliberately outside reset
  always_ff @(posedge clk) begin
    result_q <= result_d;
  end

  sar_engine u_engine (
    .clk(clk),
    .rst_n(rst_n),
    .eng(step),
    .comp_hi(comp_hi),
    .tap_code(tap_code),
    .sample_hold(sample_hold)
  );

  assign rd_data = rd_q;
  assign analog_inputs_sel = chan_q;
  assign conv_end_irq = irq_q;
endmodule
`default_nettype wire

// ### hw/adc_defs.svh
`ifndef ADC_DEFS_SVH
`define ADC_DEFS_SVH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define ADR_RESULT 16'hFF18
`define ADR_MODE 16'hFF80
`define ADR_CHAN 16'hFF81

// ----------------------------------------
// Reset values and masks
// ----------------------------------------
`define MODE_RESET 8'h00
`define CHAN_RESET 3'h0
`define MODE_WMASK 8'hFE
`define RESULT_PAD 6'h00

// ----------------------------------------
// Mode field positions
// ----------------------------------------
`define MODE_RUN_BIT 7
`define MODE_HW_BIT 6
`define MODE_FR_HI 5
`define MODE_FR_LO 3
`define MODE_EDGE_HI 2
`define MODE_EDGE_LO 1

// ----------------------------------------
// Conversion timing
// ----------------------------------------
// A conversion is 12 equal steps: 2 sample steps plus 10 bit steps
`define STEPS_PER_CONV 12
`define CONV_CLKS_144 144
`define CONV_CLKS_120 120
`define CONV_CLKS_96 96
`define CONV_CLKS_72 72
`define CONV_CLKS_60 60
`define CONV_CLKS_48 48
`define SAMPLE_STEPS 2

`endif

// ### hw/adc_pkg.sv
`default_nettype none
package adc_pkg;
  typedef logic [9:0] sar_word_t;
  typedef logic [3:0] step_len_t;
  typedef logic [2:0] chan_t;
  typedef enum logic [2:0] {
    CTL_IDLE = 3'b001,
    CTL_WAIT_TRIG = 3'b010,
    CTL_BUSY = 3'b100
  } ctl_state_t;
  typedef enum logic [2:0] {
    ENG_IDLE = 3'b001,
    ENG_SAMPLE = 3'b010,
    ENG_COMPARE = 3'b100
  } eng_state_t;
  typedef enum logic [1:0] {
    EDGE_NONE = 2'b00,
    EDGE_FALL = 2'b01,
    EDGE_RISE = 2'b10,
    EDGE_BOTH = 2'b11
  } edge_sel_t;
endpackage
`default_nettype wire

// ### hw/sar_step_if.sv
`default_nettype none
interface sar_step_if;
  import adc_pkg::*;
  logic start;
  logic abort;
  step_len_t step_len;
  logic done;
  sar_word_t sar_value;
  modport ctrl (output start, output abort, output step_len, input done, input sar_value);
  modport engine (input start, input abort, input step_len, output done, output sar_value);
endinterface
`default_nettype wire

// ### hw/sar_engine.sv
`default_nettype none
`include "adc_defs.svh"
module sar_engine (
  input wire logic clk,
  input wire logic rst_n,
  sar_step_if.engine eng,
  input wire logic comp_hi,
  output logic [9:0] tap_code,
  output logic sample_hold
);
  import adc_pkg::*;

  eng_state_t state_q, state_d;
  step_len_t cnt_q, cnt_d;
  logic [3:0] bit_q, bit_d;
  logic samp_step_q, samp_step_d;
  sar_word_t sar_q, sar_d;
  logic done_q, done_d;
  logic sh_q, sh_d;
  logic step_end;

  assign step_end = (cnt_q == eng.step_len - 4'h1);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    state_d = state_q;
    cnt_d = step_end ? 4'h0 : cnt_q + 4'h1;
    bit_d = bit_q;
    samp_step_d = samp_step_q;
    sar_d = sar_q;
    done_d = 1'b0;
    sh_d = sh_q;
    if (eng.abort) begin
      // Abort and restart land together on a rewrite; restart wins so no start is lost
      state_d = ENG_IDLE;
      sh_d = 1'b0;
      cnt_d = 4'h0;
      if (eng.start) begin
        state_d = ENG_SAMPLE;
        samp_step_d = 1'b0;
        sh_d = 1'b1;
      end
    end else begin
      case (state_q)
        ENG_IDLE: begin
          cnt_d = 4'h0;
          if (eng.start) begin
            state_d = ENG_SAMPLE;
            samp_step_d = 1'b0;
            sh_d = 1'b1;
          end
        end
        ENG_SAMPLE: begin
          if (step_end) begin
            samp_step_d = 1'b1;
            if (samp_step_q == 1'b1) begin
              // Hold, then try the top bit first
              state_d = ENG_COMPARE;
              sh_d = 1'b0;
              bit_d = 4'h9;
              sar_d = 10'h200;
            end
          end
        end
        ENG_COMPARE: begin
          if (step_end) begin
            // Comparator decides the bit under trial
            if (!comp_hi) begin
              sar_d[bit_q] = 1'b0;
            end
            if (bit_q == 4'h0) begin
              done_d = 1'b1;
              state_d = ENG_IDLE;
            end else begin
              bit_d = bit_q - 4'h1;
              sar_d[bit_q - 4'h1] = 1'b1;
            end
          end
        end
        default: state_d = ENG_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= ENG_IDLE;
      cnt_q <= 4'h0;
      bit_q <= 4'h0;
      samp_step_q <= 1'b0;
      sar_q <= 10'h000;
      done_q <= 1'b0;
      sh_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      bit_q <= bit_d;
      samp_step_q <= samp_step_d;
      sar_q <= sar_d;
      done_q <= done_d;
      sh_q <= sh_d;
    end
  end

  assign eng.done = done_q;
  assign eng.sar_value = sar_q;
  assign tap_code = sar_q; // Trial code to the tap selector
  assign sample_hold = sh_q;
endmodule
`default_nettype wire

// ### tb/sar_adc_controller_assertions.sv
`default_nettype none
`include "adc_defs.svh"
module sar_adc_checker (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [15:0] addr,
  input wire logic byte_wr,
  input wire logic [7:0] wr_data,
  input wire logic bit_wr,
  input wire logic rd_en,
  input wire logic [15:0] rd_data,
  input wire logic sample_hold,
  input wire logic [2:0] analog_inputs_sel,
  input wire logic conv_end_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Port relations
  // ----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [2:0] wlo;
  logic cfg_wr;
  logic map_rd;
  assign wlo = wr_data[2:0];
  assign cfg_wr = (byte_wr && (addr == `ADR_MODE || addr == `ADR_CHAN)) || (bit_wr && addr == `ADR_MODE);
  assign map_rd = addr == `ADR_RESULT || addr == `ADR_MODE || addr == `ADR_CHAN;
  property p_irq_gap;
    conv_end_irq |=> !conv_end_irq [*8];
  endproperty
  a_irq_gap: assert property (p_irq_gap) else $error("irq gap");
  property p_abort;
    cfg_wr |=> !conv_end_irq [*8];
  endproperty
  a_abort: assert property (p_abort) else $error("irq after abort");
  property p_stop;
    byte_wr && addr == `ADR_MODE && !wr_data[7] |-> ##2 (!sample_hold && !conv_end_irq) [*8];
  endproperty
  a_stop: assert property (p_stop) else $error("runs when stopped");
  property p_pad;
    rd_en && addr == `ADR_RESULT |=> rd_data[5:0] == 6'h00;
  endproperty
  a_pad: assert property (p_pad) else $error("result pad");
  property p_unmapped;
    rd_en && !map_rd |=> rd_data == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
  property p_rd_hold;
    !rd_en |=> $stable(rd_data);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
  property p_chan;
    byte_wr && addr == `ADR_CHAN |=> analog_inputs_sel == $past(wlo);
  endproperty
  a_chan: assert property (p_chan) else $error("channel select");
  property p_mode_rd;
    byte_wr && addr == `ADR_MODE ##1 rd_en && addr == `ADR_MODE && !byte_wr && !bit_wr
      |=> rd_data == {8'h00, $past(wr_data, 2) & `MODE_WMASK};
  endproperty
  a_mode_rd: assert property (p_mode_rd) else $error("mode readback");
  c_irq: cover property (conv_end_irq);
  c_abort: cover property (cfg_wr ##[1:300] conv_end_irq);
  c_stop: cover property (byte_wr && addr == `ADR_MODE && !wr_data[7]);
endmodule
`default_nettype wire

// ### tb/analog_front_model.sv
`default_nettype none
module analog_front_model (
  input wire logic clk,
  input wire logic slow,
  input wire logic [9:0] tap_code,
  input wire logic sample_hold,
  input wire logic [2:0] analog_inputs_sel,
  output logic comp_hi
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Held level ch*100+45, compared to tap
  // ----------------------------------------
  logic [9:0] held = 10'h000;
  logic late = 1'b0;
  always @(posedge clk) begin
    // Pins only reach the hold, never read as a digital port
    if (sample_hold) held <= 10'(analog_inputs_sel * 100 + 45);
    late <= held >= tap_code;
  end
  // Slow mode settles a cycle late; steps of 4+ clocks still see it
  assign comp_hi = slow ? late : held >= tap_code;
endmodule
`default_nettype wire

// ### tb/tb_sar_adc_controller.sv
`default_nettype none
`include "adc_defs.svh"
module tb_sar_adc_controller;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------
  // Bench
  // ----------------------------------------
  logic clk = 1'b0, rst_n = 1'b0, byte_wr = 1'b0, bit_wr = 1'b0, bit_val = 1'b0, rd_en = 1'b0;
  logic ext_conv_trigger = 1'b0, slow = 1'b0, comp_hi, sample_hold, conv_end_irq;
  logic [15:0] addr = 16'h0000, rd_data, v;
  logic [7:0] wr_data = 8'h00;
  logic [2:0] bit_idx = 3'h0, analog_inputs_sel;
  logic [9:0] tap_code;
  int failures = 0, num_checks = 0, irqs = 0, cyc = 0, t0, n, tc;
  int stp[8] = '{12, 10, 8, 12, 6, 5, 4, 12};
  int codes[8] = '{0, 1, 2, 4, 5, 6, 3, 7};
  initial forever #4 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (conv_end_irq === 1'b1) irqs <= irqs + 1;
  end
  sar_adc_controller u_sar_adc_controller (.clk(clk), .rst_n(rst_n), .addr(addr), .byte_wr(byte_wr),
    .wr_data(wr_data), .bit_wr(bit_wr), .bit_idx(bit_idx), .bit_val(bit_val), .rd_en(rd_en),
    .rd_data(rd_data), .ext_conv_trigger(ext_conv_trigger), .comp_hi(comp_hi), .tap_code(tap_code),
    .sample_hold(sample_hold), .analog_inputs_sel(analog_inputs_sel), .conv_end_irq(conv_end_irq));
  analog_front_model u_analog_front_model (.clk(clk), .slow(slow), .tap_code(tap_code),
    .sample_hold(sample_hold), .analog_inputs_sel(analog_inputs_sel), .comp_hi(comp_hi));
  // Kind 1 byte write, 2 bit write (d = {value, idx}), 3 read, 0 idle
  task automatic acc(input int k, input logic [15:0] a, input logic [7:0] d);
    byte_wr <= k == 1;
    bit_wr <= k == 2;
    rd_en <= k == 3;
    addr <= a;
    wr_data <= d;
    bit_idx <= d[2:0];
    bit_val <= d[7];
    @(posedge clk);
  endtask
  task automatic idle(input int c);
    repeat (c) acc(0, 16'h0000, 8'h00);
  endtask
  task automatic rd(input logic [15:0] a);
    acc(3, a, 8'h00);
    idle(1);
    v = rd_data;
  endtask
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wait_irq(input int lim);
    int n0;
    n0 = irqs;
    repeat (lim) if (irqs == n0) idle(1);
    if (irqs == n0) check("irq", 16'h0000, 16'h0001);
  endtask
  function automatic logic [15:0] res(input int ch);
    return {10'(ch * 100 + 45), 6'h00};
  endfunction
  task automatic end_of_test;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #(8 * 40000);
    failures++;
    end_of_test;
  end
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rd(`ADR_MODE);
    check("mode", v, 16'h0000);
    rd(`ADR_CHAN);
    check("chan", v, 16'h0000);
    rd(16'h1234);
    check("unmapped", v, 16'h0000);
    $display("test reset done");
    // Every channel and time code, bit0 written high must read low
    for (int ch = 0; ch < 8; ch++) begin
      tc = codes[ch];
      slow <= ch[0];
      acc(1, `ADR_CHAN, 8'(ch));
      acc(1, `ADR_MODE, 8'(8'h81 | (tc << 3)));
      rd(`ADR_MODE);
      check("mode", v, {8'h00, 8'(8'h80 | (tc << 3))});
      wait_irq(200);
      t0 = cyc;
      wait_irq(200);
      check("period", 16'(cyc - t0 >= 12 * stp[tc]), 16'h0001);
      rd(`ADR_RESULT);
      check("result", v, res(ch));
    end
    slow <= 1'b0;
    acc(1, `ADR_RESULT, 8'hFF);
    rd(`ADR_RESULT);
    check("readonly", v, res(7));
    acc(1, `ADR_MODE, 8'h00);
    // Let a pulse already in flight be counted before the baseline
    idle(1);
    n = irqs;
    idle(300);
    check("stopped", 16'(irqs - n), 16'h0000);
    $display("test software start done");
    acc(2, `ADR_MODE, 8'h87);
    rd(`ADR_MODE);
    check("bitset", v, 16'h0080);
    wait_irq(200);
    acc(2, `ADR_MODE, 8'h07);
    rd(`ADR_MODE);
    check("bitclr", v, 16'h0000);
    $display("test bit write done");
    // One shot per allowed edge; edges none, fall, rise, both
    for (int e = 0; e < 4; e++) begin
      acc(1, `ADR_MODE, 8'(8'hF0 | (e << 1)));
      n = irqs;
      ext_conv_trigger <= 1'b1;
      idle(150);
      ext_conv_trigger <= 1'b0;
      idle(150);
      check("hw", 16'(irqs - n), 16'(e[0] + e[1]));
    end
    $display("test hardware start done");
    acc(1, `ADR_CHAN, 8'h02);
    acc(1, `ADR_MODE, 8'h80);
    idle(60);
    acc(1, `ADR_CHAN, 8'h05);
    t0 = cyc;
    wait_irq(300);
    check("restart", 16'(cyc - t0 >= 144), 16'h0001);
    rd(`ADR_RESULT);
    check("abort", v, res(5));
    acc(1, `ADR_MODE, 8'h00);
    $display("test abort done");
    end_of_test;
  end
endmodule
bind sar_adc_controller sar_adc_checker u_sar_adc_checker (.clk(clk), .rst_n(rst_n), .addr(addr),
  .byte_wr(byte_wr), .wr_data(wr_data), .bit_wr(bit_wr), .rd_en(rd_en), .rd_data(rd_data),
  .sample_hold(sample_hold), .analog_inputs_sel(analog_inputs_sel), .conv_end_irq(conv_end_irq));
`default_nettype wire
